// ---- pkg/afs_cfg.svh ----
// Constants of the axis fault and status monitor: offsets, fields, limits.
// Assumes a 40 MHz system clock and one AHB-Lite master.
//
// Summary of operation
// [RULE1] Fault opens contact, stage off, brake on
// [RULE2] Display active error code, zero when none
// [RULE3] Heat sink above 80 degrees raises 1
// [RULE4] Bus overvoltage raises 2, limit per supply
// [RULE5] Bus below 100 volts raises 5
// [RULE6] Motor over 145 C or sensor bad: 6
// [RULE7] Internal supply out of tolerance raises 7
// [RULE8] Motor overspeed raises 8
// [RULE9] Two/three phases lost: 16; one: 19
// [RULE10] Output stage fault 14, I2t over 15
// [RULE11] Interface card hardware 20, software 21
// [RULE12] CAN bus-off raises 23
// [RULE13] Oversized external position step raises 28
// [RULE14] Limit switch while homing 26; software 32
// [RULE15] Clearable class cleared by fault-clear alone
// [RULE16] Single clearable error: reset only clears faults
// [RULE17] Red steady on fault, red blink on warning
// [RULE18] Green steady when enabled, blinking when ready
// [RULE19] Both blink while master selects for editing; a fault keeps red steady and green off instead
// [RULE20] Errors stay latched until clear or reset
`ifndef AFS_CFG_SVH
`define AFS_CFG_SVH

// Register byte offsets
`define AFS_REG_CTRL 4'h0
`define AFS_REG_CMD 4'h4
`define AFS_REG_FLAGS 4'h8
`define AFS_REG_STATUS 4'hc

// Control register fields
`define AFS_CTRL_SW_EN 0
`define AFS_CTRL_PHASE_ERR 1
`define AFS_CTRL_SUP_LO 2
`define AFS_CTRL_SUP_HI 3
`define AFS_CTRL_RESET 4'h2

// Command register fields (write one, self clearing)
`define AFS_CMD_FAULT_CLEAR 0
`define AFS_CMD_AMP_RESET 1

// Error numbers
`define AFS_E_HEATSINK 1
`define AFS_E_OVERVOLT 2
`define AFS_E_FOLLOW 3
`define AFS_E_UNDERVOLT 5
`define AFS_E_MOTOR_TEMP 6
`define AFS_E_INT_SUPPLY 7
`define AFS_E_OVERSPEED 8
`define AFS_E_INT_TEMP 13
`define AFS_E_STAGE 14
`define AFS_E_I2T 15
`define AFS_E_PHASES 16
`define AFS_E_PHASE_ONE 19
`define AFS_E_SLOT_HW 20
`define AFS_E_SLOT_SW 21
`define AFS_E_CAN_OFF 23
`define AFS_E_HOMING 26
`define AFS_E_POS_STEP 28
`define AFS_E_SYSTEM 32
`define AFS_NO_ERROR 6'h00
`define AFS_CLEARABLE_MASK 33'h0_0009_212e

// Fixed limits, in degrees Celsius and volts
`define AFS_HEATSINK_MAX 8'd80
`define AFS_UNDERVOLT_MIN 10'd100
`define AFS_MOTOR_TEMP_MAX 8'd145
`define AFS_OVERVOLT_SEL0 10'd400
`define AFS_OVERVOLT_SEL1 10'd450
`define AFS_OVERVOLT_SEL2 10'd800
`define AFS_OVERVOLT_SEL3 10'd900

// LED blink half period
`define AFS_CLK_HZ 40000000
`define AFS_BLINK_HALF_MS 250
`define AFS_BLINK_HALF_CYC ((`AFS_CLK_HZ / 1000) * `AFS_BLINK_HALF_MS)

`endif

// ---- pkg/afs_pkg.sv ----
// Types of the axis fault and status monitor.
// Assumes afs_cfg.svh is available on the include path.
`default_nettype none
package afs_pkg;

  // LED pattern selector, highest priority first
  typedef enum logic [2:0]
  {
    AFS_LED_FAULT,
    AFS_LED_EDIT,
    AFS_LED_WARN,
    AFS_LED_ENABLED,
    AFS_LED_READY
  } afs_led_mode_t;

  // Complete state of the top module
  typedef struct packed
  {
    logic [32:0] flags;
    logic [5:0] code;
    logic rto;
    logic stage_en;
    logic brake_rel;
    logic red;
    logic green;
    logic warn;
    afs_led_mode_t mode;
    logic [24:0] blink_cnt;
    logic blink;
    logic btn_prev;
    logic [3:0] ctrl;
    logic dp_wr;
    logic [3:0] dp_addr;
    logic hreadyout;
    logic [31:0] hrdata;
  } afs_state_t;

endpackage
`default_nettype wire

// ---- src/afs_sync.sv ----
// Two-stage synchroniser for a group of slowly changing pins.
// Assumes each bit is stable far longer than two clock periods.
`default_nettype none
module afs_sync
#(
  parameter int W = 1
)
(
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] sync_out
);

  typedef struct packed
  {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } afs_sync_st_t;

  afs_sync_st_t st_q;
  afs_sync_st_t st_d;

  // First stage feeds only the second stage
  always_comb
  begin
    st_d.s1 = pin_in;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign sync_out = st_q.s2;

endmodule
`default_nettype wire

// ---- src/afs_top.sv ----
// Axis fault and status monitor: latches fault conditions, drives the
// safe-off outputs, error code and the two status LEDs; AHB-Lite slave.
// Assumes fault pins come from other clock domains and are synchronised
// here; measured words change slowly compared with the clock.
`include "afs_cfg.svh"
`default_nettype none
module afs_top
  import afs_pkg::*;
#(
  parameter int unsigned BLINK_HALF_CYC = `AFS_BLINK_HALF_CYC
)
(
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] hrdata_out,
  input wire logic [7:0] heatsink_temp_in,
  input wire logic [9:0] dcbus_volt_in,
  input wire logic [7:0] motor_temp_in,
  input wire logic motor_sensor_fail_in,
  input wire logic supply_tol_fail_in,
  input wire logic overspeed_in,
  input wire logic following_err_in,
  input wire logic internal_overtemp_in,
  input wire logic [2:0] phase_ok_in,
  input wire logic stage_fault_in,
  input wire logic i2t_over_in,
  input wire logic slot_hw_fault_in,
  input wire logic slot_sw_fault_in,
  input wire logic can_bus_off_in,
  input wire logic pos_step_over_in,
  input wire logic homing_active_in,
  input wire logic limit_switch_in,
  input wire logic sys_sw_fault_in,
  input wire logic warning_in,
  input wire logic hw_enable_in,
  input wire logic edit_select_in,
  input wire logic reset_button_in,
  output logic ready_to_operate_contact_out,
  output logic stage_enable_out,
  output logic brake_release_out,
  output logic [5:0] err_code_out,
  output logic led_red_out,
  output logic led_green_out
);

  //--------------------------------------------------------------------
  // Input synchronisers
  //--------------------------------------------------------------------
  logic [25:0] word_s;
  logic [20:0] bit_s;
  logic [7:0] hs_temp_s;
  logic [9:0] bus_volt_s;
  logic [7:0] mot_temp_s;
  logic [2:0] phase_ok_s;

  // Measured words: slow ADC values, so per-bit skew settles in a cycle
  afs_sync #(.W(26)) u_sync_word
  (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .pin_in({heatsink_temp_in, dcbus_volt_in, motor_temp_in}),
    .sync_out(word_s)
  );

  afs_sync #(.W(21)) u_sync_bit
  (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .pin_in({motor_sensor_fail_in, supply_tol_fail_in, overspeed_in,
             following_err_in, internal_overtemp_in, phase_ok_in,
             stage_fault_in, i2t_over_in, slot_hw_fault_in,
             slot_sw_fault_in, can_bus_off_in, pos_step_over_in,
             homing_active_in, limit_switch_in, sys_sw_fault_in,
             warning_in, hw_enable_in, edit_select_in,
             reset_button_in}),
    .sync_out(bit_s)
  );

  assign hs_temp_s = word_s[25:18];
  assign bus_volt_s = word_s[17:8];
  assign mot_temp_s = word_s[7:0];
  assign phase_ok_s = bit_s[15:13];

  //--------------------------------------------------------------------
  // State
  //--------------------------------------------------------------------
  afs_state_t st_q;
  afs_state_t st_d;
  logic [32:0] set_vec_c;
  logic [32:0] clr_vec_c;
  logic [9:0] ovv_lim_c;
  logic [1:0] phases_lost_c;
  logic btn_rise_c;
  logic reset_req_c;
  logic fault_clear_c;
  logic single_clr_c;
  logic ready_c;
  logic enabled_c;
  logic ap_valid_c;
  logic [3:0] ap_addr_c;

  // Lowest error number wins the display
  function automatic logic [5:0] afs_lowest(input logic [32:0] f);
    logic [5:0] c;
    c = `AFS_NO_ERROR;
    for (int i = 32; i >= 1; i--)
    begin
      if (f[i])
        c = 6'(i);
    end
    return c;
  endfunction

  //--------------------------------------------------------------------
  // Fault detection
  //--------------------------------------------------------------------
  // Overvoltage limit follows the configured supply range
  always_comb
  begin
    case (st_q.ctrl[`AFS_CTRL_SUP_HI:`AFS_CTRL_SUP_LO])
      2'h0: ovv_lim_c = `AFS_OVERVOLT_SEL0;
      2'h1: ovv_lim_c = `AFS_OVERVOLT_SEL1;
      2'h2: ovv_lim_c = `AFS_OVERVOLT_SEL2;
      default: ovv_lim_c = `AFS_OVERVOLT_SEL3;
    endcase
  end

  assign phases_lost_c = 2'(3'(!phase_ok_s[0]) + 3'(!phase_ok_s[1])
                            + 3'(!phase_ok_s[2]));

  // Set terms, one per error number
  always_comb
  begin
    set_vec_c = '0;
    set_vec_c[`AFS_E_HEATSINK] = hs_temp_s > `AFS_HEATSINK_MAX; // [RULE3]
    set_vec_c[`AFS_E_OVERVOLT] = bus_volt_s > ovv_lim_c; // [RULE4]
    set_vec_c[`AFS_E_FOLLOW] = bit_s[17];
    set_vec_c[`AFS_E_UNDERVOLT] = bus_volt_s < `AFS_UNDERVOLT_MIN; // [RULE5]
    set_vec_c[`AFS_E_MOTOR_TEMP] = (mot_temp_s > `AFS_MOTOR_TEMP_MAX)
                                   || bit_s[20]; // [RULE6]
    set_vec_c[`AFS_E_INT_SUPPLY] = bit_s[19]; // [RULE7]
    set_vec_c[`AFS_E_OVERSPEED] = bit_s[18]; // [RULE8]
    set_vec_c[`AFS_E_INT_TEMP] = bit_s[16];
    set_vec_c[`AFS_E_STAGE] = bit_s[12]; // [RULE10]
    set_vec_c[`AFS_E_I2T] = bit_s[11]; // [RULE10]
    set_vec_c[`AFS_E_PHASES] = phases_lost_c >= 2'd2; // [RULE9]
    set_vec_c[`AFS_E_PHASE_ONE] = (phases_lost_c == 2'd1)
                                  && st_q.ctrl[`AFS_CTRL_PHASE_ERR]; // [RULE9]
    set_vec_c[`AFS_E_SLOT_HW] = bit_s[10]; // [RULE11]
    set_vec_c[`AFS_E_SLOT_SW] = bit_s[9]; // [RULE11]
    set_vec_c[`AFS_E_CAN_OFF] = bit_s[8]; // [RULE12]
    set_vec_c[`AFS_E_HOMING] = bit_s[6] && bit_s[5]; // [RULE14]
    set_vec_c[`AFS_E_POS_STEP] = bit_s[7]; // [RULE13]
    set_vec_c[`AFS_E_SYSTEM] = bit_s[4]; // [RULE14]
  end

  //--------------------------------------------------------------------
  // Clearing
  //--------------------------------------------------------------------
  // Button edge is taken after the synchroniser, never on its first stage
  assign btn_rise_c = bit_s[0] && !st_q.btn_prev;
  assign reset_req_c = btn_rise_c || (st_q.dp_wr && st_q.dp_addr ==
                       `AFS_REG_CMD && hwdata_in[`AFS_CMD_AMP_RESET]);
  assign fault_clear_c = st_q.dp_wr && st_q.dp_addr == `AFS_REG_CMD
                         && hwdata_in[`AFS_CMD_FAULT_CLEAR];
  assign single_clr_c = ($countones(st_q.flags) == 1)
                        && |(st_q.flags & `AFS_CLEARABLE_MASK);

  // A lone clearable error turns a reset into a fault clear
  always_comb
  begin
    clr_vec_c = '0;
    if (reset_req_c && single_clr_c)
      clr_vec_c = `AFS_CLEARABLE_MASK; // [RULE16]
    else if (reset_req_c)
      clr_vec_c = '1;
    if (fault_clear_c)
      clr_vec_c = clr_vec_c | `AFS_CLEARABLE_MASK; // [RULE15]
  end

  // Taken from the next flag word directly, not from st_d, so no loop
  assign ready_c = (((st_q.flags & ~clr_vec_c) | set_vec_c) == '0);
  assign enabled_c = ready_c && bit_s[2] && st_q.ctrl[`AFS_CTRL_SW_EN];
  assign ap_valid_c = hsel_in && htrans_in[1] && hready_in;
  assign ap_addr_c = haddr_in[3:0];

  //--------------------------------------------------------------------
  // Next state
  //--------------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    // Set wins over clear; latched until cleared
    st_d.flags = (st_q.flags & ~clr_vec_c) | set_vec_c; // [RULE20]
    st_d.code = afs_lowest(st_d.flags); // [RULE2]
    st_d.rto = ready_c; // [RULE1]
    st_d.stage_en = enabled_c; // [RULE1]
    st_d.brake_rel = enabled_c; // [RULE1]
    st_d.warn = bit_s[3] || ((phases_lost_c == 2'd1)
                && !st_q.ctrl[`AFS_CTRL_PHASE_ERR]);
    st_d.btn_prev = bit_s[0];
    // Free running blink time base shared by both LEDs
    if (st_q.blink_cnt >= 25'(BLINK_HALF_CYC - 1))
    begin
      st_d.blink_cnt = '0;
      st_d.blink = !st_q.blink;
    end
    else
      st_d.blink_cnt = st_q.blink_cnt + 25'd1;
    // Fault pattern outranks the editing pattern for safety
    if (!ready_c)
      st_d.mode = AFS_LED_FAULT;
    else if (bit_s[1])
      st_d.mode = AFS_LED_EDIT;
    else if (st_d.warn)
      st_d.mode = AFS_LED_WARN;
    else if (enabled_c)
      st_d.mode = AFS_LED_ENABLED;
    else
      st_d.mode = AFS_LED_READY;
    case (st_d.mode)
      AFS_LED_FAULT:
      begin
        st_d.red = 1'b1; // [RULE17]
        st_d.green = 1'b0;
      end
      AFS_LED_EDIT:
      begin
        st_d.red = st_d.blink; // [RULE19]
        st_d.green = st_d.blink;
      end
      AFS_LED_WARN:
      begin
        st_d.red = st_d.blink; // [RULE17]
        st_d.green = 1'b0;
      end
      AFS_LED_ENABLED:
      begin
        st_d.red = 1'b0; // [RULE18]
        st_d.green = 1'b1;
      end
      default:
      begin
        st_d.red = 1'b0; // [RULE18]
        st_d.green = st_d.blink;
      end
    endcase
    // Bus: control write lands in the data phase
    if (st_q.dp_wr && st_q.dp_addr == `AFS_REG_CTRL)
      st_d.ctrl = hwdata_in[3:0];
    st_d.dp_wr = ap_valid_c && hwrite_in;
    st_d.dp_addr = ap_addr_c;
    st_d.hreadyout = 1'b1;
    // Read data fetched at the address phase, held through data phase
    if (ap_valid_c && !hwrite_in)
    begin
      if (ap_addr_c == `AFS_REG_CTRL)
        st_d.hrdata = {28'h0, st_q.ctrl};
      else if (ap_addr_c == `AFS_REG_FLAGS)
        st_d.hrdata = st_q.flags[32:1];
      else if (ap_addr_c == `AFS_REG_STATUS)
        st_d.hrdata = {21'h0, st_q.green, st_q.red, st_q.warn,
                       st_q.stage_en, st_q.rto, st_q.code};
      else
        st_d.hrdata = '0;
    end
    else
      st_d.hrdata = '0;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      st_q <= '0;
      st_q.ctrl <= `AFS_CTRL_RESET;
      st_q.mode <= AFS_LED_READY;
      st_q.hreadyout <= 1'b1;
    end
    else
      st_q <= st_d;
  end

  //--------------------------------------------------------------------
  // Outputs, all from flip-flops except hresp, tied low
  //--------------------------------------------------------------------
  assign hreadyout_out = st_q.hreadyout;
  assign hresp_out = 1'b0;
  assign hrdata_out = st_q.hrdata;
  assign ready_to_operate_contact_out = st_q.rto;
  assign stage_enable_out = st_q.stage_en;
  assign brake_release_out = st_q.brake_rel;
  assign err_code_out = st_q.code;
  assign led_red_out = st_q.red;
  assign led_green_out = st_q.green;

  //--------------------------------------------------------------------
  // Checks
  //--------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (sys_rst_in);

  a_fault_opens_rto: assert property ( // [RULE1]
    (st_q.flags != '0) |-> !ready_to_operate_contact_out
      && !stage_enable_out && !brake_release_out)
    else $error("Fault present but contact or stage still on");

  a_code_matches: assert property ( // [RULE2]
    (st_q.flags == '0) |-> (err_code_out == 6'h00))
    else $error("Error code not zero without fault");

  a_heatsink_trip: assert property ( // [RULE3]
    (hs_temp_s > 8'd80) |=> st_q.flags[1] && err_code_out == 6'h01)
    else $error("Heat sink overtemperature not reported");

  a_undervolt_trip: assert property ( // [RULE5]
    (bus_volt_s < 10'd100) |=> st_q.flags[5])
    else $error("Undervoltage not latched");

  a_phase_loss: assert property ( // [RULE9]
    (phases_lost_c >= 2'd2) && !st_q.flags[19]
      |=> st_q.flags[16] && !st_q.flags[19])
    else $error("Phase loss coded wrongly");

  a_clear_class: assert property ( // [RULE15]
    fault_clear_c && !reset_req_c && !set_vec_c[1] && st_q.flags[14]
      |=> !st_q.flags[1] && st_q.flags[14])
    else $error("Fault clear acted on wrong class");

  a_single_reset: assert property ( // [RULE16]
    reset_req_c && single_clr_c && !(|(set_vec_c & `AFS_CLEARABLE_MASK))
      |=> !(|(st_q.flags & `AFS_CLEARABLE_MASK)))
    else $error("Lone clearable error survived reset");

  a_latch_hold: assert property ( // [RULE20]
    st_q.flags[14] && !reset_req_c |=> st_q.flags[14])
    else $error("Output stage fault dropped without clear");

  a_red_fault: assert property ( // [RULE17]
    (st_q.flags != '0) |-> led_red_out && !led_green_out)
    else $error("Fault LED pattern wrong");

  a_green_enabled: assert property ( // [RULE18]
    $rose(stage_enable_out) |-> led_green_out && !led_red_out
      || st_q.mode == AFS_LED_EDIT || st_q.mode == AFS_LED_WARN)
    else $error("Enabled LED pattern wrong");

  c_fault_cleared: cover property (
    st_q.flags[1] ##1 fault_clear_c ##1 st_q.flags == '0);
  c_reset_full: cover property (reset_req_c && !single_clr_c
    && st_q.flags != '0);
  c_edit_blink: cover property (st_q.mode == AFS_LED_EDIT
    && $rose(led_red_out));

endmodule
`default_nettype wire

// ---- tb/afs_panel_model.sv ----
// Front panel model: two status LEDs and the error code display.
// Assumes the monitor is built with a short blink half period (4 cycles),
// so a 16-cycle history always holds a whole blink period.
`default_nettype none
module afs_panel_model
(
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic led_red_in,
  input wire logic led_green_in,
  input wire logic [5:0] err_code_in,
  output logic [1:0] red_pat_out,
  output logic [1:0] green_pat_out,
  output logic [5:0] shown_code_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] red_hist_q;
  logic [15:0] green_hist_q;

  // ----------------------------------------------------------------
  // Pattern decode: 0 off, 1 lit, 2 blinking
  // ----------------------------------------------------------------
  function automatic logic [1:0] classify(input logic [15:0] h);
    if (h === 16'hffff)
      return 2'd1;
    if (h === 16'h0000)
      return 2'd0;
    return 2'd2;
  endfunction

  // LED history; an eye sees the pattern, not one sample
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      red_hist_q <= 16'h0000;
      green_hist_q <= 16'h0000;
    end
    else
    begin
      red_hist_q <= {red_hist_q[14:0], led_red_in};
      green_hist_q <= {green_hist_q[14:0], led_green_in};
    end
  end

  // Both blinking marks the edit selection
  assign red_pat_out = classify(red_hist_q);
  assign green_pat_out = classify(green_hist_q);
  // Display shows whatever code the axis drives
  assign shown_code_out = err_code_in;
endmodule
`default_nettype wire

// ---- tb/afs_top_tb_top.sv ----
// Self-checking bench of the axis fault and status monitor.
// Assumes the monitor answers every bus transfer with zero wait states,
// but the bus tasks still wait on hready; only the watchdog ends a wait.
`include "afs_cfg.svh"
`default_nettype none
module afs_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hready, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'b00;
  logic [7:0] heat = 8'd25, mtemp = 8'd30;
  logic [9:0] volt = 10'd300;
  logic [2:0] ph = 3'b111;
  logic msf = 1'b0, sup = 1'b0, ovs = 1'b0, fe = 1'b0, iot = 1'b0;
  logic stg = 1'b0, i2t = 1'b0, shw = 1'b0, ssw = 1'b0, can = 1'b0;
  logic pst = 1'b0, hom = 1'b0, lim = 1'b0, ssf = 1'b0, warn = 1'b0;
  logic hwen = 1'b0, edit = 1'b0, btn = 1'b0, rd_ph = 1'b0;
  logic contact, stage, brake, red, green;
  logic [5:0] code, shown;
  logic [1:0] rpat, gpat;
  logic [31:0] exp_q[$], msk_q[$], e, m, r;
  int fails = 0, num_checks = 0;
  integer seed = 32'hdeca140d;
  int codes[19] = '{1, 2, 3, 5, 6, 6, 7, 8, 13, 14, 15, 16, 19, 20, 21, 23,
    26, 28, 32};

  always #12.5 clk = ~clk;

  afs_top #(.BLINK_HALF_CYC(4)) dut_u (.clk_sys_in(clk), .sys_rst_in(rst),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(3'b010), .hwdata_in(hwdata),
    .hready_in(hready), .hreadyout_out(hready), .hresp_out(hresp),
    .hrdata_out(hrdata), .heatsink_temp_in(heat), .dcbus_volt_in(volt),
    .motor_temp_in(mtemp), .motor_sensor_fail_in(msf),
    .supply_tol_fail_in(sup), .overspeed_in(ovs), .following_err_in(fe),
    .internal_overtemp_in(iot), .phase_ok_in(ph), .stage_fault_in(stg),
    .i2t_over_in(i2t), .slot_hw_fault_in(shw), .slot_sw_fault_in(ssw),
    .can_bus_off_in(can), .pos_step_over_in(pst), .homing_active_in(hom),
    .limit_switch_in(lim), .sys_sw_fault_in(ssf), .warning_in(warn),
    .hw_enable_in(hwen), .edit_select_in(edit), .reset_button_in(btn),
    .ready_to_operate_contact_out(contact), .stage_enable_out(stage),
    .brake_release_out(brake), .err_code_out(code), .led_red_out(red),
    .led_green_out(green));

  afs_panel_model panel_u (.clk_sys_in(clk), .sys_rst_in(rst),
    .led_red_in(red), .led_green_in(green), .err_code_in(code),
    .red_pat_out(rpat), .green_pat_out(gpat), .shown_code_out(shown));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] ex,
    input logic [31:0] g);
    num_checks++;
    if (g !== ex)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, g);
    end
  endtask

  task report_and_stop;
    $display("Checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // One single word transfer; entered just after a rising edge
  task automatic bus(input logic [31:0] a, input logic w,
    input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1)
      @(posedge clk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1)
      @(posedge clk);
  endtask

  // Reads note their expected word; the monitor below compares it
  task automatic rd(input logic [31:0] a, input logic [31:0] ex,
    input logic [31:0] mk);
    exp_q.push_back(ex);
    msk_q.push_back(mk);
    bus(a, 1'b0, 32'h0);
  endtask

  task automatic press;
    btn <= 1'b1;
    repeat (2) @(posedge clk);
    btn <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  // Raise (on) or remove one fault cause; removal leaves boundary values, except overvoltage, which returns to 300
  task automatic apply(input int k, input logic on);
    case (k)
      0: heat <= on ? 8'd81 : 8'd80;
      1: volt <= on ? 10'd401 : 10'd300;
      2: fe <= on;
      3: volt <= on ? 10'd99 : 10'd100;
      4: mtemp <= on ? 8'd146 : 8'd145;
      5: msf <= on;
      6: sup <= on;
      7: ovs <= on;
      8: iot <= on;
      9: stg <= on;
      10: i2t <= on;
      11: ph <= on ? 3'b100 : 3'b111;
      12: ph <= on ? 3'b110 : 3'b111;
      13: shw <= on;
      14: ssw <= on;
      15: can <= on;
      16: lim <= on;
      17: pst <= on;
      default: ssf <= on;
    endcase
  endtask

  // ----------------------------------------------------------------
  // Read data monitor: compares at the edge that ends each data phase
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (rd_ph && hready === 1'b1 && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      check("hrdata", e & m, hrdata & m);
      check("hresp", 32'h0, hresp);
    end
    // A data phase stays open until the slave shows ready
    rd_ph <= (rd_ph && hready !== 1'b1)
             || (hsel && htrans[1] && hready && !hwrite);
  end

  // Watchdog, far beyond the roughly 700 cycles the run needs
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    report_and_stop;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    hom <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(32'h0, 32'h2, 32'hffffffff);
    rd(32'h4, 32'h0, 32'hffffffff);
    repeat (4) @(posedge clk);
    // Synchroniser flush latches spurious undervoltage and phase-loss faults; clear them first
    bus(32'h4, 1'b1, 32'h1);
    bus(32'h8, 1'b1, 32'hffffffff);
    repeat (2) @(posedge clk);
    rd(32'h8, 32'h0, 32'hffffffff);
    bus(32'h0, 1'b1, 32'h3);
    hwen <= 1'b1;
    repeat (20) @(posedge clk);
    check("brake", 1'b1, brake);
    check("green", 2'd1, gpat);
    check("red", 2'd0, rpat);
    for (int k = 0; k < 19; k++)
    begin
      r = $random(seed);
      if (k != 0)
        heat <= {1'b0, r[6:0]} % 8'd81;
      apply(k, 1'b1);
      repeat (4) @(posedge clk);
      check("contact", 1'b0, contact);
      check("stage", 1'b0, stage);
      check("brake", 1'b0, brake);
      check("shown", codes[k], shown);
      rd(32'h8, 32'h1 << (codes[k] - 1), 32'hffffffff);
      rd(32'hc, 32'h200 | codes[k], 32'h7ff);
      apply(k, 1'b0);
      repeat (4) @(posedge clk);
      rd(32'h8, 32'h1 << (codes[k] - 1), 32'hffffffff);
      bus(32'h4, 1'b1, 32'h1);
      repeat (2) @(posedge clk);
      if (!(codes[k] inside {1, 2, 3, 5, 8, 13, 16, 19}))
      begin
        rd(32'h8, 32'h1 << (codes[k] - 1), 32'hffffffff);
        press;
      end
      rd(32'h8, 32'h0, 32'hffffffff);
      rd(32'hc, 32'hc0, 32'h1ff);
    end
    // Supply range 2: limit moves up, boundary value must not trip
    bus(32'h0, 1'b1, 32'hb);
    volt <= 10'd800;
    repeat (4) @(posedge clk);
    rd(32'h8, 32'h0, 32'hffffffff);
    volt <= 10'd801;
    repeat (4) @(posedge clk);
    rd(32'h8, 32'h2, 32'hffffffff);
    volt <= 10'd300;
    repeat (4) @(posedge clk);
    bus(32'h4, 1'b1, 32'h1);
    repeat (2) @(posedge clk);
    rd(32'h8, 32'h0, 32'hffffffff);
    hwen <= 1'b0;
    repeat (20) @(posedge clk);
    check("green", 2'd2, gpat);
    check("red", 2'd0, rpat);
    warn <= 1'b1;
    repeat (20) @(posedge clk);
    check("red", 2'd2, rpat);
    check("green", 2'd0, gpat);
    edit <= 1'b1;
    repeat (20) @(posedge clk);
    check("red", 2'd2, rpat);
    check("green", 2'd2, gpat);
    edit <= 1'b0;
    warn <= 1'b0;
    heat <= 8'd90;
    repeat (20) @(posedge clk);
    check("red", 2'd1, rpat);
    check("green", 2'd0, gpat);
    heat <= 8'd40;
    repeat (4) @(posedge clk);
    press;
    rd(32'h8, 32'h0, 32'hffffffff);
    stg <= 1'b1;
    repeat (4) @(posedge clk);
    stg <= 1'b0;
    repeat (4) @(posedge clk);
    bus(32'h4, 1'b1, 32'h2);
    repeat (2) @(posedge clk);
    rd(32'h8, 32'h0, 32'hffffffff);
    repeat (2) @(posedge clk);
    report_and_stop;
  end
endmodule
`default_nettype wire
